// *** rtl/trim_regs_pkg.sv ***
// Register map, field layout and carrier types of the antenna trim and AM depth register group
package trim_regs_pkg;
	// Offsets 0x0e and 0x0f are not word multiples, so they are indices; byte address is four times the index
	localparam logic [7:0] idx_cal_result = 8'h0e;
	localparam logic [7:0] idx_manual_trim = 8'h0f;
	localparam logic [7:0] idx_am_depth = 8'h10;
	localparam logic [7:0] idx_manual_level = 8'h12;
	localparam logic [7:0] idx_irq_status = 8'h20;
	localparam logic [7:0] idx_irq_mask = 8'h21;
	localparam logic [7:0] idx_control = 8'h22;
	localparam int addr_lsb = 2;
	localparam int idx_width = 8;
	localparam logic [7:0] reg_reset = 8'h00;
	localparam logic [3:0] trim_reset = 4'h0;
	localparam logic [5:0] depth_reset = 6'h00;
	localparam logic [2:0] irq_reset = 3'h0;
	// Field positions
	localparam int cal_trim_msb = 7;
	localparam int cal_trim_lsb = 4;
	localparam int cal_err_bit = 3;
	localparam int trim_sel_bit = 7;
	localparam int man_trim_msb = 6;
	localparam int man_trim_lsb = 3;
	localparam int am_sel_bit = 7;
	localparam int depth_msb = 6;
	localparam int depth_lsb = 1;
	localparam int ctrl_default_bit = 0;
	// Interrupt status bits
	localparam int irq_cal_done = 0;
	localparam int irq_cal_err = 1;
	localparam int irq_depth_done = 2;
	localparam int irq_bits = 3;

	typedef struct packed {
		logic [3:0] trim;
		logic err;
	} cal_result_type;

	typedef struct packed {
		logic am_sel;
		logic [5:0] auto_depth;
		logic [7:0] manual_level;
	} am_level_type;
endpackage

// *** rtl/trim_select.sv ***
// Trim switch source multiplexer, one generate slice per switch
`timescale 1ns/10ps
module trim_select #(
	parameter int trim_width = 4
) (
	// Selection
	input wire logic manual_sel,
	input wire logic [trim_width-1:0] cal_trim,
	input wire logic [trim_width-1:0] manual_trim,
	// Switch drives
	output logic [trim_width-1:0] first_trim_pin_set,
	output logic [trim_width-1:0] second_trim_pin_set
);
	for (genvar i = 0; i < trim_width; i++) begin : g_sw
		// Both pin sets switch together on a 1
		assign first_trim_pin_set[i] = manual_sel ? manual_trim[i] : cal_trim[i]; // [RULE2] [RULE6]
		assign second_trim_pin_set[i] = manual_sel ? manual_trim[i] : cal_trim[i]; // [RULE2] [RULE6]
	end
endmodule

// *** rtl/am_level_select.sv ***
// AM modulated level source selection and driver segment disables
`timescale 1ns/10ps
module am_level_select (
	// Selection
	input wire trim_regs_pkg::am_level_type level_in,
	// Segment disables, 1 turns a segment off in the modulated state
	output logic [7:0] am_segment_disable
);
	always_comb begin
		if (level_in.am_sel) begin
			am_segment_disable = level_in.manual_level; // [RULE9] [RULE10]
		end else begin
			// Six-bit depth code sits in the low segments; top two stay enabled
			am_segment_disable = {2'h0, level_in.auto_depth}; // [RULE8]
		end
	end
endmodule

// *** rtl/trim_am_regs.sv ***
// APB register group for antenna trim calibration result, manual trim and AM depth
`timescale 1ns/10ps
// How it works
// RULE1: The calibration outcome nibble is stored in bits 7..4 of the read-only result register, bit 7 most significant.
// RULE2: With trim source 0 each trim switch on both pin sets follows the matching calibration result bit.
// RULE3: A failed calibration sets the error flag in bit 3 of the result register.
// RULE4: Reset and the set-default command clear the whole result register.
// RULE5: Bit 7 of the manual trim register selects calibration result (0) or manual bits (1) for the switches.
// RULE6: With trim source 1 the switches on both pin sets follow manual bits 6..3.
// RULE7: Reset and set-default clear every field of the manual trim register.
// RULE8: With AM source 0 the modulated level comes from the 6-bit depth field in bits 6..1.
// RULE9: With AM source 1 the modulated level comes from the 8-bit manual driver level register.
// RULE10: In manual mode each 1 bit of the manual level disables the matching driver segment.
// RULE11: Unused low bits of the result and manual trim registers read zero and ignore writes.
module trim_am_regs (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Calibration engines
	input wire logic set_default,
	input wire logic cal_done,
	input wire logic cal_fail,
	input wire logic [3:0] cal_trim_in,
	input wire logic depth_done,
	input wire logic [5:0] depth_in,
	// Trim switches and driver
	output logic [3:0] first_trim_pin_set,
	output logic [3:0] second_trim_pin_set,
	output logic [7:0] am_segment_disable,
	// Interrupt
	output logic irq
);
	typedef struct packed {
		trim_regs_pkg::cal_result_type cal;
		logic trim_sel;
		logic [3:0] man_trim;
		trim_regs_pkg::am_level_type am;
		logic [2:0] irq_status;
		logic [2:0] irq_mask;
		logic [31:0] rdata;
		logic done;
		logic err;
	} state_type;

	state_type state_reg;
	state_type state_next;
	logic [7:0] idx;
	logic aligned;
	logic access;
	logic wr;
	logic rd;
	logic mapped;
	logic [7:0] rd_val;
	logic [2:0] events;
	logic default_cmd;

	assign idx = paddr[trim_regs_pkg::addr_lsb +: trim_regs_pkg::idx_width];
	assign aligned = paddr[1:0] == 2'h0;
	// Only the first access cycle acts, so a read clear cannot swallow an event in the wait state
	assign access = psel && penable && clk_en && !state_reg.done;
	assign wr = access && pwrite && pstrb[0] && mapped && aligned;
	assign rd = access && !pwrite && mapped && aligned;
	assign events = {depth_done, cal_fail, cal_done};
	assign default_cmd = set_default || (wr && idx == trim_regs_pkg::idx_control && pwdata[trim_regs_pkg::ctrl_default_bit]);

	always_comb begin
		mapped = 1'b1;
		rd_val = trim_regs_pkg::reg_reset;
		unique case (idx)
			trim_regs_pkg::idx_cal_result: begin
				rd_val = {state_reg.cal.trim, state_reg.cal.err, 3'h0}; // [RULE1] [RULE3] [RULE11]
			end
			trim_regs_pkg::idx_manual_trim: begin
				rd_val = {state_reg.trim_sel, state_reg.man_trim, 3'h0}; // [RULE11]
			end
			trim_regs_pkg::idx_am_depth: begin
				rd_val = {state_reg.am.am_sel, state_reg.am.auto_depth, 1'b0};
			end
			trim_regs_pkg::idx_manual_level: begin
				rd_val = state_reg.am.manual_level;
			end
			trim_regs_pkg::idx_irq_status: begin
				rd_val = {5'h00, state_reg.irq_status};
			end
			trim_regs_pkg::idx_irq_mask: begin
				rd_val = {5'h00, state_reg.irq_mask};
			end
			trim_regs_pkg::idx_control: begin
				rd_val = trim_regs_pkg::reg_reset;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	always_comb begin
		state_next = state_reg;
		if (access) begin
			state_next.rdata = {24'h000000, rd_val};
		end
		// One wait state: ready and error follow the first access cycle
		state_next.done = psel && penable && !state_reg.done;
		state_next.err = psel && penable && !state_reg.done && !(mapped && aligned);
		if (cal_done || cal_fail) begin
			state_next.cal.trim = cal_trim_in; // [RULE1]
			state_next.cal.err = cal_fail; // [RULE3]
		end
		if (depth_done) begin
			state_next.am.auto_depth = depth_in; // [RULE8]
		end
		if (wr) begin
			unique case (idx)
				trim_regs_pkg::idx_manual_trim: begin
					state_next.trim_sel = pwdata[trim_regs_pkg::trim_sel_bit]; // [RULE5]
					state_next.man_trim = pwdata[trim_regs_pkg::man_trim_msb:trim_regs_pkg::man_trim_lsb]; // [RULE6]
				end
				trim_regs_pkg::idx_am_depth: begin
					state_next.am.am_sel = pwdata[trim_regs_pkg::am_sel_bit];
					if (!depth_done) begin
						state_next.am.auto_depth = pwdata[trim_regs_pkg::depth_msb:trim_regs_pkg::depth_lsb];
					end
				end
				trim_regs_pkg::idx_manual_level: begin
					state_next.am.manual_level = pwdata[7:0];
				end
				trim_regs_pkg::idx_irq_mask: begin
					state_next.irq_mask = pwdata[trim_regs_pkg::irq_bits-1:0];
				end
				default: begin
				end
			endcase
		end
		// Read clears status, but an event in the same cycle survives
		if (rd && idx == trim_regs_pkg::idx_irq_status) begin
			state_next.irq_status = events;
		end else begin
			state_next.irq_status = state_reg.irq_status | events;
		end
		// Set-default acts last so it beats any write or engine update to the trim and AM fields
		if (default_cmd) begin
			state_next.cal = '0; // [RULE4]
			state_next.trim_sel = 1'b0; // [RULE7]
			state_next.man_trim = trim_regs_pkg::trim_reset; // [RULE7]
			state_next.am = '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0; // [RULE4] [RULE7]
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	assign prdata = state_reg.rdata;
	// Read data is registered at the access edge and presented with ready one cycle later
	assign pready = state_reg.done;
	assign pslverr = state_reg.done && state_reg.err;
	assign irq = |(state_reg.irq_status & state_reg.irq_mask);

	trim_select #(
		.trim_width(4)
	) u_trim (
		.manual_sel(state_reg.trim_sel),
		.cal_trim(state_reg.cal.trim),
		.manual_trim(state_reg.man_trim),
		.first_trim_pin_set(first_trim_pin_set),
		.second_trim_pin_set(second_trim_pin_set)
	);

	am_level_select u_am (
		.level_in(state_reg.am),
		.am_segment_disable(am_segment_disable)
	);

	// Trim switches follow the selected source
	trim_follow_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
		!state_reg.trim_sel
		|-> first_trim_pin_set == state_reg.cal.trim && second_trim_pin_set == state_reg.cal.trim)
		else $error("trim pins do not follow calibration result");
	trim_manual_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
		state_reg.trim_sel
		|-> first_trim_pin_set == state_reg.man_trim && second_trim_pin_set == state_reg.man_trim)
		else $error("trim pins do not follow manual bits");

	// Calibration result capture, read-back and read-only behaviour
	cal_store_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
		clk_en && cal_done && !cal_fail && !default_cmd
		|=> state_reg.cal.trim == $past(cal_trim_in) && !state_reg.cal.err)
		else $error("calibration result not stored");
	cal_error_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
		clk_en && cal_fail && !default_cmd
		|=> state_reg.cal.err)
		else $error("calibration error flag not set");
	default_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
		clk_en && default_cmd
		|=> state_reg.cal == '0 && !state_reg.trim_sel && state_reg.man_trim == trim_regs_pkg::trim_reset)
		else $error("set-default did not clear trim registers");
	cal_read_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
		rd && idx == trim_regs_pkg::idx_cal_result
		|=> prdata[trim_regs_pkg::cal_trim_msb:trim_regs_pkg::cal_trim_lsb] == $past(state_reg.cal.trim))
		else $error("calibration nibble not read back in place");
	err_read_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
		rd && idx == trim_regs_pkg::idx_cal_result
		|=> prdata[trim_regs_pkg::cal_err_bit] == $past(state_reg.cal.err))
		else $error("calibration error flag not read back in place");
	cal_ro_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
		wr && idx == trim_regs_pkg::idx_cal_result && !cal_done && !cal_fail && !set_default
		|=> state_reg.cal == $past(state_reg.cal))
		else $error("write changed the read-only calibration result");
	low_bits_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE11]
		rd && (idx == trim_regs_pkg::idx_cal_result || idx == trim_regs_pkg::idx_manual_trim)
		|=> prdata[2:0] == 3'h0)
		else $error("unused low bits read nonzero");

	// Manual trim register
	trim_sel_wr_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
		wr && idx == trim_regs_pkg::idx_manual_trim && !set_default
		|=> state_reg.trim_sel == $past(pwdata[trim_regs_pkg::trim_sel_bit]))
		else $error("trim source select not written");
	man_trim_wr_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
		wr && idx == trim_regs_pkg::idx_manual_trim && !set_default
		|=> state_reg.man_trim == $past(pwdata[trim_regs_pkg::man_trim_msb:trim_regs_pkg::man_trim_lsb]))
		else $error("manual trim bits not written");
	trim_read_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
		rd && idx == trim_regs_pkg::idx_manual_trim
		|=> prdata[trim_regs_pkg::trim_sel_bit] == $past(state_reg.trim_sel)
		&& prdata[trim_regs_pkg::man_trim_msb:trim_regs_pkg::man_trim_lsb] == $past(state_reg.man_trim))
		else $error("manual trim register not read back in place");
	trim_reset_a: assert property (@(posedge pclk) // [RULE7]
		$rose(presetn)
		|-> state_reg.man_trim == trim_regs_pkg::trim_reset && !state_reg.trim_sel)
		else $error("manual trim not zero after reset");

	// AM level source
	auto_level_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
		!state_reg.am.am_sel
		|-> am_segment_disable == {2'h0, state_reg.am.auto_depth})
		else $error("automatic depth not selected");
	manual_level_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9] [RULE10]
		state_reg.am.am_sel
		|-> am_segment_disable == state_reg.am.manual_level)
		else $error("manual level not selected");
	am_sel_wr_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
		wr && idx == trim_regs_pkg::idx_am_depth && !set_default
		|=> state_reg.am.am_sel == $past(pwdata[trim_regs_pkg::am_sel_bit]))
		else $error("AM level source bit not written");
	depth_store_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
		clk_en && depth_done && !default_cmd
		|=> state_reg.am.auto_depth == $past(depth_in))
		else $error("calibrated depth not stored");
	level_wr_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
		wr && idx == trim_regs_pkg::idx_manual_level && !set_default
		|=> state_reg.am.manual_level == $past(pwdata[7:0]))
		else $error("manual driver level not written");

	// Bus handshake: one wait state, error only with ready
	pready_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && psel && penable && !pready
		|=> pready)
		else $error("ready not given after one wait state");
	pready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && pready
		|=> !pready)
		else $error("ready held longer than one cycle");
	err_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr
		|-> pready)
		else $error("error response without ready");
	unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && psel && penable && !pready && !(mapped && aligned)
		|=> pslverr)
		else $error("unmapped access not answered with error");
	rdata_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
		pready
		|-> prdata[31:8] == 24'h000000)
		else $error("upper read data bits nonzero");

	// Sticky interrupt status
	status_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && events != 3'h0
		|=> (state_reg.irq_status & $past(events)) == $past(events))
		else $error("event did not set its status bit");
	status_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		rd && idx == trim_regs_pkg::idx_irq_status && events == 3'h0
		|=> state_reg.irq_status == 3'h0)
		else $error("status read did not clear status");
	mask_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr && idx == trim_regs_pkg::idx_irq_mask
		|=> state_reg.irq_mask == $past(pwdata[trim_regs_pkg::irq_bits-1:0]))
		else $error("interrupt mask not written");

	// Clock enable low freezes everything
	freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
		!clk_en
		|=> state_reg == $past(state_reg))
		else $error("state changed while clock enable low");
endmodule

// *** dv/trim_switch_model.sv ***
// Model of the LC trim switches that both trim pin sets drive
`timescale 1ns/10ps
module trim_switch_model (
	// Pin sets
	input wire logic [3:0] first_set,
	input wire logic [3:0] second_set,
	// Switch state
	output logic [3:0] switch_on,
	output logic sets_differ
);
	// A transistor conducts only when both of its pins are driven on
	assign switch_on = first_set & second_set;
	assign sets_differ = (first_set !== second_set);
endmodule

// *** dv/trim_am_regs_bench.sv ***
// Self-checking bench of the antenna trim and AM depth register group
`timescale 1ns/10ps
module trim_am_regs_bench;
	logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, irq, err, sets_differ;
	logic set_default, cal_done, cal_fail, depth_done;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] cal_trim_in, first_set, second_set, switch_on;
	logic [5:0] depth_in;
	logic [7:0] seg_off;
	int n_fail, n_compared, cycles;

	trim_am_regs trim_am_regs_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .set_default(set_default),
		.cal_done(cal_done), .cal_fail(cal_fail), .cal_trim_in(cal_trim_in), .depth_done(depth_done),
		.depth_in(depth_in), .first_trim_pin_set(first_set), .second_trim_pin_set(second_set),
		.am_segment_disable(seg_off), .irq(irq));
	trim_switch_model trim_switch_model_inst (.first_set(first_set), .second_set(second_set),
		.switch_on(switch_on), .sets_differ(sets_differ));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task complete_run;
		if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// Counts and reports one comparison
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Registered pready and prdata still show pre-edge values when the task wakes on the edge
	task apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// No cycle count is assumed; the bench timeout ends a hung wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~wd;
	endtask

	task rdchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		chk(what, exp, rd);
	endtask

	task pulse_cal(input logic fail, input logic [3:0] t);
		@(posedge pclk);
		cal_done <= ~fail;
		cal_fail <= fail;
		cal_trim_in <= t;
		@(posedge pclk);
		cal_done <= 1'b0;
		cal_fail <= 1'b0;
		cal_trim_in <= ~t;
		// Let the captured result reach the outputs before the caller looks
		@(posedge pclk);
	endtask

	task test_reset;
		rdchk("cal_result", trim_regs_pkg::idx_cal_result, 32'h0);
		rdchk("manual_trim", trim_regs_pkg::idx_manual_trim, 32'h0);
		chk("pins", 32'h0, {28'h0, first_set});
	endtask

	task test_cal_result;
		apb(1'b1, trim_regs_pkg::idx_irq_mask, 32'h7);
		pulse_cal(1'b0, 4'ha);
		rdchk("cal_result", trim_regs_pkg::idx_cal_result, 32'ha0);
		chk("switch_on", 32'ha, {28'h0, switch_on});
		chk("irq", 32'h1, {31'h0, irq});
		rdchk("irq_status", trim_regs_pkg::idx_irq_status, 32'h1);
		@(posedge pclk);
		chk("irq", 32'h0, {31'h0, irq});
		pulse_cal(1'b1, 4'h5);
		apb(1'b1, trim_regs_pkg::idx_cal_result, 32'hff);
		rdchk("cal_result", trim_regs_pkg::idx_cal_result, 32'h58);
		rdchk("irq_status", trim_regs_pkg::idx_irq_status, 32'h2);
	endtask

	task test_manual_trim;
		apb(1'b1, trim_regs_pkg::idx_manual_trim, 32'hff);
		rdchk("manual_trim", trim_regs_pkg::idx_manual_trim, 32'hf8);
		chk("switch_on", 32'hf, {28'h0, switch_on});
		apb(1'b1, trim_regs_pkg::idx_manual_trim, 32'h18);
		chk("switch_on", 32'h5, {28'h0, switch_on});
		apb(1'b1, trim_regs_pkg::idx_manual_trim, 32'h98);
		chk("switch_on", 32'h3, {28'h0, switch_on});
		chk("sets_differ", 32'h0, {31'h0, sets_differ});
	endtask

	task test_am_level;
		@(posedge pclk);
		depth_done <= 1'b1;
		depth_in <= 6'h2b;
		@(posedge pclk);
		depth_done <= 1'b0;
		depth_in <= 6'h14;
		@(posedge pclk);
		chk("seg_off", 32'h2b, {24'h0, seg_off});
		rdchk("am_depth", trim_regs_pkg::idx_am_depth, 32'h56);
		apb(1'b1, trim_regs_pkg::idx_manual_level, 32'hc3);
		apb(1'b1, trim_regs_pkg::idx_am_depth, 32'hd6);
		chk("seg_off", 32'hc3, {24'h0, seg_off});
		rdchk("irq_status", trim_regs_pkg::idx_irq_status, 32'h4);
	endtask

	task test_mask_and_errors;
		apb(1'b1, trim_regs_pkg::idx_irq_mask, 32'h0);
		pulse_cal(1'b0, 4'h1);
		chk("irq", 32'h0, {31'h0, irq});
		rdchk("irq_status", trim_regs_pkg::idx_irq_status, 32'h1);
		chk("pslverr", 32'h0, {31'h0, err});
		apb(1'b1, 8'h3f, 32'h1);
		chk("pslverr", 32'h1, {31'h0, err});
	endtask

	task test_set_default;
		apb(1'b1, trim_regs_pkg::idx_control, 32'h1);
		rdchk("cal_result", trim_regs_pkg::idx_cal_result, 32'h0);
		rdchk("manual_trim", trim_regs_pkg::idx_manual_trim, 32'h0);
		chk("seg_off", 32'h0, {24'h0, seg_off});
		apb(1'b1, trim_regs_pkg::idx_manual_trim, 32'h98);
		rdchk("manual_trim", trim_regs_pkg::idx_manual_trim, 32'h98);
		pulse_cal(1'b0, 4'h9);
		rdchk("cal_result", trim_regs_pkg::idx_cal_result, 32'h90);
		@(posedge pclk);
		set_default <= 1'b1;
		@(posedge pclk);
		set_default <= 1'b0;
		rdchk("manual_trim", trim_regs_pkg::idx_manual_trim, 32'h0);
		rdchk("cal_result", trim_regs_pkg::idx_cal_result, 32'h0);
	endtask

	// Clock enable low must freeze state, and a mid-run reset must clear it
	task test_freeze_and_reset;
		apb(1'b1, trim_regs_pkg::idx_manual_trim, 32'hd0);
		@(posedge pclk);
		clk_en <= 1'b0;
		pulse_cal(1'b0, 4'h7);
		clk_en <= 1'b1;
		rdchk("cal_result", trim_regs_pkg::idx_cal_result, 32'h0);
		chk("switch_on", 32'ha, {28'h0, switch_on});
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rdchk("manual_trim", trim_regs_pkg::idx_manual_trim, 32'h0);
		chk("switch_on", 32'h0, {28'h0, switch_on});
	endtask

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			complete_run;
		end
	end

	initial begin
		{presetn, psel, penable, pwrite, set_default, cal_done, cal_fail, depth_done} = 8'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		cal_trim_in = 4'h0;
		depth_in = 6'h00;
		clk_en = 1'b1;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		test_reset;
		test_cal_result;
		test_manual_trim;
		test_am_level;
		test_mask_and_errors;
		test_set_default;
		test_freeze_and_reset;
		complete_run;
	end
endmodule
